// ===== core/nfh_host.sv
// NAND flash host controller: sequences commands, addresses and data
`timescale 1ns/10ps
`include "nfh_regs.svh"
// How it works
// - After ECC status command, four sector status bytes are read.
// - ECC status command is only sent when ready is high, as its own operation; a read goes from busy straight to its data bytes.
// - Consecutive programs to one page are counted and refused beyond four; a program to another page restarts the count.
// - Block addresses at or past the usable count are flagged to the user.
// - Addresses go out in four bytes: two column, then two row (block and page); erase sends the two row bytes only.
// - Operations use the documented command pairs; status and reset while busy.
module nfh_host #(
   parameter int FETCH_TO = `NFH_FETCH_MAX_US * `NFH_CYC_PER_US,
   parameter int PROG_TO  = `NFH_PROG_MAX_US * `NFH_CYC_PER_US,
   parameter int ERASE_TO = `NFH_ERASE_MAX_US * `NFH_CYC_PER_US,
   parameter int RST_TO   = `NFH_RST_MAX_US * `NFH_CYC_PER_US
) (
   // Clock and reset
   input  wire logic            clk_i,
   input  wire logic            rst_n_i,
   // User command port
   input  wire logic            cmd_valid_i,
   output logic                 cmd_ready_o,
   input  wire nfh_pkg::nfh_op_e cmd_op_i,
   input  wire logic [11:0]     col_i,
   input  wire logic [5:0]      page_i,
   input  wire logic [9:0]      block_i,
   input  wire logic [11:0]     len_i,
   // Write data stream
   input  wire logic            wr_valid_i,
   output logic                 wr_ready_o,
   input  wire logic [7:0]      wr_data_i,
   // Read data stream
   output logic                 rd_valid_o,
   output logic [7:0]           rd_data_o,
   // Completion
   output logic                 done_o,
   output logic                 error_o,
   output logic                 bad_block_o,
   // Flash pins
   output logic                 chip_sel_n_o,
   output logic                 cle_o,
   output logic                 ale_o,
   output logic                 write_strobe_n_o,
   output logic                 read_strobe_n_o,
   output logic                 write_protect_n_o,
   output logic [7:0]           io_o,
   output logic                 io_oe_n_o,
   input  wire logic [7:0]      io_i,
   input  wire logic            ready_busy_n_i
);
   typedef enum logic [3:0] {
      NFH_IDLE, NFH_CMD1, NFH_ADDR, NFH_WDATA, NFH_CMD2, NFH_WAITB, NFH_BUSY,
      NFH_RDATA, NFH_FIN
   } nfh_state_e;

   nfh_pin_if pin ();

   nfh_state_e       state;
   nfh_pkg::nfh_op_e op;
   logic [7:0]  addr [4];
   logic [1:0]  aidx;
   logic [2:0]  nadr;
   logic [11:0] left;
   logic [31:0] tmo;
   logic [6:0]  wbc;
   logic        rb_s1, rb_s2, rb_s3, rb;
   logic [15:0] last_row;
   logic [2:0]  part_cnt;
   logic        issued;
   logic        fail;

   // Ready-busy is a pin: three flops, level changes once stages agree
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rb_s1 <= 1'b1;
         rb_s2 <= 1'b1;
         rb_s3 <= 1'b1;
         rb    <= 1'b1;
      end else begin
         rb_s1 <= ready_busy_n_i;
         rb_s2 <= rb_s1;
         rb_s3 <= rb_s2;
         if (rb_s2 == rb_s3) begin
            rb <= rb_s3;
         end
      end
   end

   nfh_pin_drv u_drv (
      .clk_i            (clk_i),
      .rst_n_i          (rst_n_i),
      .pin              (pin.drv),
      .cle_o            (cle_o),
      .ale_o            (ale_o),
      .write_strobe_n_o (write_strobe_n_o),
      .read_strobe_n_o  (read_strobe_n_o),
      .io_o             (io_o),
      .io_oe_n_o        (io_oe_n_o),
      .io_i             (io_i)
   );

   logic [7:0] cmd1, cmd2;
   always_comb begin
      unique case (op)
         nfh_pkg::NFH_OP_READ:    begin cmd1 = `NFH_CMD_READ1;   cmd2 = `NFH_CMD_READ2;  end
         nfh_pkg::NFH_OP_PROGRAM: begin cmd1 = `NFH_CMD_PROG1;   cmd2 = `NFH_CMD_PROG2;  end
         nfh_pkg::NFH_OP_ERASE:   begin cmd1 = `NFH_CMD_ERASE1;  cmd2 = `NFH_CMD_ERASE2; end
         nfh_pkg::NFH_OP_STATUS:  begin cmd1 = `NFH_CMD_STATUS;  cmd2 = 8'h00;           end
         nfh_pkg::NFH_OP_ECCSTAT: begin cmd1 = `NFH_CMD_ECCSTAT; cmd2 = 8'h00;           end
         default:                 begin cmd1 = `NFH_CMD_RESET;   cmd2 = 8'h00;           end
      endcase
   end

   // Pin phase request
   always_comb begin
      pin.req      = 1'b0;
      pin.is_write = 1'b1;
      pin.cle      = 1'b0;
      pin.ale      = 1'b0;
      pin.wdata    = 8'h00;
      unique case (state)
         NFH_CMD1:  begin pin.req = !issued; pin.cle = 1'b1; pin.wdata = cmd1; end
         NFH_CMD2:  begin pin.req = !issued; pin.cle = 1'b1; pin.wdata = cmd2; end
         NFH_ADDR:  begin pin.req = !issued; pin.ale = 1'b1; pin.wdata = addr[aidx]; end
         NFH_WDATA: begin pin.req = !issued && wr_valid_i; pin.wdata = wr_data_i; end
         NFH_RDATA: begin pin.req = !issued; pin.is_write = 1'b0; end
         default:   pin.req = 1'b0;
      endcase
   end

   assign wr_ready_o  = (state == NFH_WDATA) && !issued;
   assign cmd_ready_o = (state == NFH_IDLE);

   logic [15:0] row;
   assign row = {block_i, page_i};

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state             <= NFH_IDLE;
         op                <= nfh_pkg::NFH_OP_RESET;
         for (int i = 0; i < 4; i++) addr[i] <= 8'h00;
         aidx              <= 2'd0;
         nadr              <= 3'd0;
         left              <= 12'h000;
         tmo               <= 32'h0;
         wbc               <= 7'h00;
         issued            <= 1'b0;
         fail              <= 1'b0;
         last_row          <= 16'hFFFF;
         part_cnt          <= 3'd0;
         chip_sel_n_o      <= 1'b1;
         write_protect_n_o <= 1'b0;
         rd_valid_o        <= 1'b0;
         rd_data_o         <= 8'h00;
         done_o            <= 1'b0;
         error_o           <= 1'b0;
         bad_block_o       <= 1'b0;
      end else begin
         done_o     <= 1'b0;
         rd_valid_o <= 1'b0;
         if (pin.req) issued <= 1'b1;
         if (pin.done) issued <= 1'b0;
         unique case (state)
            NFH_IDLE: begin
               chip_sel_n_o      <= 1'b1;
               write_protect_n_o <= 1'b0;
               if (cmd_valid_i && (rb || cmd_op_i == nfh_pkg::NFH_OP_STATUS
                                   || cmd_op_i == nfh_pkg::NFH_OP_RESET)) begin
                  op   <= cmd_op_i;
                  fail <= 1'b0;
                  bad_block_o <= ({1'b0, block_i} >= `NFH_MIN_GOOD_BLKS);
                  addr[0] <= col_i[7:0];
                  addr[1] <= {4'h0, col_i[11:8]};
                  addr[2] <= row[7:0];
                  addr[3] <= row[15:8];
                  aidx <= (cmd_op_i == nfh_pkg::NFH_OP_ERASE) ? 2'd2 : 2'd0;
                  unique case (cmd_op_i)
                     nfh_pkg::NFH_OP_READ, nfh_pkg::NFH_OP_PROGRAM: nadr <= 3'd4;
                     nfh_pkg::NFH_OP_ERASE: nadr <= 3'd2;
                     default: nadr <= 3'd0;
                  endcase
                  left <= (cmd_op_i == nfh_pkg::NFH_OP_ECCSTAT) ? 12'(`NFH_SECTORS)
                        : (cmd_op_i == nfh_pkg::NFH_OP_STATUS) ? 12'd1
                        : ((len_i > `NFH_PAGE_BYTES - col_i) ? `NFH_PAGE_BYTES - col_i
                                                              : len_i);
                  if (cmd_op_i == nfh_pkg::NFH_OP_PROGRAM) begin
                     if (row == last_row && part_cnt >= `NFH_MAX_PARTIAL) begin
                        error_o <= 1'b1;
                        done_o  <= 1'b1;
                     end else begin
                        part_cnt <= (row == last_row) ? part_cnt + 3'd1 : 3'd1;
                        last_row <= row;
                        write_protect_n_o <= 1'b1;
                        chip_sel_n_o <= 1'b0;
                        error_o <= 1'b0;
                        state <= NFH_CMD1;
                     end
                  end else begin
                     if (cmd_op_i == nfh_pkg::NFH_OP_ERASE) begin
                        write_protect_n_o <= 1'b1;
                        if (row[15:6] == last_row[15:6]) last_row <= 16'hFFFF;
                     end
                     chip_sel_n_o <= 1'b0;
                     error_o <= 1'b0;
                     state <= NFH_CMD1;
                  end
               end
            end
            NFH_CMD1: if (pin.done) begin
               if (nadr != 3'd0) state <= NFH_ADDR;
               else if (op == nfh_pkg::NFH_OP_RESET) state <= NFH_WAITB;
               else state <= NFH_RDATA;
            end
            NFH_ADDR: if (pin.done) begin
               aidx <= aidx + 2'd1;
               nadr <= nadr - 3'd1;
               if (nadr == 3'd1) state <= (op == nfh_pkg::NFH_OP_PROGRAM) ? NFH_WDATA : NFH_CMD2;
            end
            NFH_WDATA: if (pin.done) begin
               left <= left - 12'd1;
               if (left == 12'd1) state <= NFH_CMD2;
            end
            NFH_CMD2: if (pin.done) state <= NFH_WAITB;
            NFH_WAITB: begin
               // Busy may take up to the write-high-to-busy time to show
               wbc <= wbc + 7'd1;
               if (wbc == 7'(`NFH_WB_CYC + 4)) begin
                  wbc <= 7'h00;
                  unique case (op)
                     nfh_pkg::NFH_OP_READ:    tmo <= 32'(FETCH_TO);
                     nfh_pkg::NFH_OP_PROGRAM: tmo <= 32'(PROG_TO);
                     nfh_pkg::NFH_OP_ERASE:   tmo <= 32'(ERASE_TO);
                     default:                 tmo <= 32'(RST_TO);
                  endcase
                  state <= NFH_BUSY;
               end
            end
            NFH_BUSY: begin
               // Chip select stays low; dropping it would not stop the flash
               tmo <= tmo - 32'd1;
               if (rb) begin
                  state <= (op == nfh_pkg::NFH_OP_READ) ? NFH_RDATA : NFH_FIN;
               end else if (tmo == 32'd0) begin
                  fail  <= 1'b1;
                  state <= NFH_FIN;
               end
            end
            NFH_RDATA: if (pin.done) begin
               rd_valid_o <= 1'b1;
               rd_data_o  <= pin.rdata;
               left <= left - 12'd1;
               if (left <= 12'd1) state <= NFH_FIN;
            end
            NFH_FIN: begin
               done_o  <= 1'b1;
               error_o <= fail;
               write_protect_n_o <= 1'b0;
               chip_sel_n_o <= 1'b1;
               state <= NFH_IDLE;
            end
            default: state <= NFH_IDLE;
         endcase
      end
   end
endmodule // nfh_host

// ===== core/nfh_pin_drv.sv
// One strobe cycle on the flash pins: a write or a read byte
`timescale 1ns/10ps
`include "nfh_regs.svh"
module nfh_pin_drv (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // Sequencer side
   nfh_pin_if.drv          pin,
   // Flash pins
   output logic            cle_o,
   output logic            ale_o,
   output logic            write_strobe_n_o,
   output logic            read_strobe_n_o,
   output logic [7:0]      io_o,
   output logic            io_oe_n_o,
   input  wire logic [7:0] io_i
);
   typedef enum logic [1:0] {NFH_D_IDLE, NFH_D_LOW, NFH_D_HIGH} nfh_drv_e;
   localparam int CYC = `NFH_STROBE_CYC;

   nfh_drv_e   state;
   logic [3:0] cnt;
   logic [7:0] io_s1, io_s2, io_s3;

   // Read data pass three flops; a byte is taken once stages two and three agree
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         io_s1 <= 8'h00;
         io_s2 <= 8'h00;
         io_s3 <= 8'h00;
      end else begin
         io_s1 <= io_i;
         io_s2 <= io_s1;
         io_s3 <= io_s2;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state            <= NFH_D_IDLE;
         cnt              <= 4'h0;
         cle_o            <= 1'b0;
         ale_o            <= 1'b0;
         write_strobe_n_o <= 1'b1;
         read_strobe_n_o  <= 1'b1;
         io_o             <= 8'h00;
         io_oe_n_o        <= 1'b1;
         pin.rdata        <= 8'h00;
      end else begin
         unique case (state)
            NFH_D_IDLE: begin
               if (pin.req) begin
                  cle_o <= pin.cle;
                  ale_o <= pin.ale;
                  io_o  <= pin.wdata;
                  io_oe_n_o <= !pin.is_write;
                  if (pin.is_write) begin
                     write_strobe_n_o <= 1'b0;
                  end else begin
                     read_strobe_n_o <= 1'b0;
                  end
                  cnt   <= 4'(CYC + 2);
                  state <= NFH_D_LOW;
               end
            end
            NFH_D_LOW: begin
               if (cnt == 4'h0) begin
                  // Rising write strobe latches command or address byte
                  write_strobe_n_o <= 1'b1;
                  read_strobe_n_o  <= 1'b1;
                  if (io_s2 == io_s3) begin
                     pin.rdata <= io_s3;
                  end
                  cnt   <= 4'(CYC);
                  state <= NFH_D_HIGH;
               end else begin
                  cnt <= cnt - 4'h1;
               end
            end
            NFH_D_HIGH: begin
               // Long high time keeps the read path in normal output mode
               if (cnt == 4'h0) begin
                  io_oe_n_o <= 1'b1;
                  cle_o     <= 1'b0;
                  ale_o     <= 1'b0;
                  state     <= NFH_D_IDLE;
               end else begin
                  cnt <= cnt - 4'h1;
               end
            end
            default: state <= NFH_D_IDLE;
         endcase
      end
   end

   assign pin.done = (state == NFH_D_HIGH) && (cnt == 4'h0);
endmodule // nfh_pin_drv

// ===== core/nfh_pin_if.sv
// Pin-phase carrier between sequencer and pin driver
`timescale 1ns/10ps
interface nfh_pin_if;
   logic       req;
   logic       is_write;
   logic       cle;
   logic       ale;
   logic [7:0] wdata;
   logic       done;
   logic [7:0] rdata;
   modport seq (output req, output is_write, output cle, output ale, output wdata,
                input done, input rdata);
   modport drv (input req, input is_write, input cle, input ale, input wdata,
                output done, output rdata);
endinterface

// ===== core/nfh_pkg.sv
// Types for the NAND flash host port controller
package nfh_pkg;
   typedef enum logic [2:0] {
      NFH_OP_READ,
      NFH_OP_PROGRAM,
      NFH_OP_ERASE,
      NFH_OP_STATUS,
      NFH_OP_ECCSTAT,
      NFH_OP_RESET
   } nfh_op_e;
endpackage

// ===== core/nfh_regs.svh
// Constants for the NAND flash host port controller
`ifndef NFH_REGS_SVH
`define NFH_REGS_SVH

// Command bytes
`define NFH_CMD_READ1     8'h00
`define NFH_CMD_READ2     8'h30
`define NFH_CMD_PROG1     8'h80
`define NFH_CMD_PROG2     8'h10
`define NFH_CMD_ERASE1    8'h60
`define NFH_CMD_ERASE2    8'hD0
`define NFH_CMD_STATUS    8'h70
`define NFH_CMD_ECCSTAT   8'h7A
`define NFH_CMD_RESET     8'hFF

// Array geometry
`define NFH_PAGE_BYTES    12'd2112
`define NFH_MAIN_BYTES    12'd2048
`define NFH_SPARE_BYTES   12'd64
`define NFH_PAGES_PER_BLK 8'd64
`define NFH_BLOCKS        11'd1024
`define NFH_MIN_GOOD_BLKS 11'd1004
`define NFH_SECTORS       3'd4
`define NFH_MAX_PARTIAL   3'd4

// Strobe phase length in clk cycles (25 ns write/read cycle, 12 ns pulse)
`define NFH_STROBE_NS     12
`define NFH_STROBE_CYC    ((`NFH_STROBE_NS + 9) / 10)
// Least wait from write-high to busy
`define NFH_WB_NS         100
`define NFH_WB_CYC        ((`NFH_WB_NS + 9) / 10)
// Longest time-outs for busy, in microseconds
`define NFH_FETCH_MAX_US  120
`define NFH_PROG_MAX_US   700
`define NFH_ERASE_MAX_US  10000
`define NFH_RST_MAX_US    500
`define NFH_CYC_PER_US    100

`endif

// ===== verification/nfh_flash_model.sv
// Behavioural flash device facing the host controller
`timescale 1ns/10ps
module nfh_flash_model #(
   parameter int         T_FETCH = 400,
   parameter int         T_PROG  = 900,
   parameter int         T_ERASE = 1500,
   parameter int         T_RST   = 300,
   parameter int         T_SLOW  = 5000,
   parameter logic [7:0] STAT_OK = 8'hE0,
   parameter logic [7:0] ECC_SEC = 8'h10
) (
   // Host pins
   input  wire logic       chip_sel_n_i,
   input  wire logic       cle_i,
   input  wire logic       ale_i,
   input  wire logic       write_strobe_n_i,
   input  wire logic       read_strobe_n_i,
   input  wire logic       write_protect_n_i,
   input  wire logic [7:0] io_i,
   // Bench control
   input  wire logic       slow_i,
   // Device outputs
   output logic [7:0]      io_o,
   output logic            ready_busy_n_o
);
   logic [7:0]  mem [int];
   logic [7:0]  pbuf [int];
   logic [31:0] adr = 32'h0;
   logic [7:0]  dout = 8'h00;
   logic [1:0]  mode = 2'd0;
   logic        drv = 1'b0;
   logic        standby;
   int          acnt = 0;
   int          col = 0;
   int          nrd = 0;
   time         busy_end = 0;
   initial ready_busy_n_o = 1'b1;
   // Released lines show the inverse of the last byte, never a stale match
   assign io_o = drv ? dout : ~dout;
   assign standby = chip_sel_n_i && ready_busy_n_o;
   always #10 if (!ready_busy_n_o && $time >= busy_end) ready_busy_n_o = 1'b1;
   function automatic int key(input int c);
      return int'({adr[31:16], 12'h000}) + c;
   endfunction
   task automatic go_busy(input int t);
      ready_busy_n_o = 1'b0;
      busy_end = $time + t;
   endtask
   always @(posedge write_strobe_n_i) if (!chip_sel_n_i) begin
      if (cle_i) begin
         case (io_i)
            8'h00, 8'h80: begin
               acnt = 0;
               pbuf.delete();
            end
            8'h60: acnt = 2;
            8'h30: begin
               mode = 2'd0;
               go_busy(T_FETCH);
            end
            8'h10: begin
               if (write_protect_n_i) foreach (pbuf[k]) mem[key(k)] = pbuf[k];
               go_busy(T_PROG);
            end
            8'hD0: begin
               for (int k = 0; k < 262144; k++) mem.delete(int'({adr[31:22], 18'h0}) + k);
               go_busy(slow_i ? T_SLOW : T_ERASE);
            end
            8'h70: mode = 2'd1;
            8'h7A: begin
               mode = 2'd2;
               nrd = 0;
            end
            8'hFF: go_busy(T_RST);
            default: ;
         endcase
      end else if (ale_i) begin
         if (acnt < 4) adr[8*acnt +: 8] = io_i;
         acnt++;
         col = int'(adr[11:0]);
      end else begin
         pbuf[col] = io_i;
         col++;
      end
   end
   always @(negedge read_strobe_n_i) if (!chip_sel_n_i) begin
      drv = 1'b1;
      if (mode == 2'd1) dout = STAT_OK;
      else if (mode == 2'd2) begin
         dout = ECC_SEC + 8'(nrd);
         nrd++;
      end else begin
         // Stored data is already corrected, so it comes out clean
         dout = mem.exists(key(col)) ? mem[key(col)] : 8'hFF;
         col++;
      end
   end
   always @(posedge read_strobe_n_i) drv <= #5 1'b0;
   always @(posedge chip_sel_n_i or posedge ale_i or posedge cle_i or negedge write_strobe_n_i)
      drv = 1'b0;
endmodule // nfh_flash_model

// ===== verification/nfh_host_asserts.sv
// Concurrent checks on the flash host controller pins
`timescale 1ns/10ps
module nfh_host_asserts (
   // Clock and reset
   input wire logic       clk_i,
   input wire logic       rst_n_i,
   // Observed ports
   input wire logic       cmd_valid_i,
   input wire logic       cmd_ready_o,
   input wire logic       done_o,
   input wire logic       rd_valid_o,
   input wire logic       chip_sel_n_o,
   input wire logic       cle_o,
   input wire logic       ale_o,
   input wire logic       write_strobe_n_o,
   input wire logic       read_strobe_n_o,
   input wire logic       write_protect_n_o,
   input wire logic [7:0] io_o,
   input wire logic       io_oe_n_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_wr_fall;
      $fell(write_strobe_n_o);
   endsequence
   sequence s_rd_fall;
      $fell(read_strobe_n_o);
   endsequence
   // Three quiet cycles mean the controller really sits idle
   sequence s_idle;
      (cmd_ready_o && !cmd_valid_i) [*3];
   endsequence
   chk_wr_pulse: assert property (s_wr_fall |=> !write_strobe_n_o)
      else $error("write strobe pulse too short");
   chk_latch_hold: assert property ($rose(write_strobe_n_o) |->
      $stable(cle_o) && $stable(ale_o) && $stable(io_o))
      else $error("latch or data moved with write strobe rise");
   chk_latch_excl: assert property (!(cle_o && ale_o))
      else $error("both latch selects high");
   chk_strobe_sel: assert property (!write_strobe_n_o || !read_strobe_n_o |-> !chip_sel_n_o)
      else $error("strobe without chip select");
   chk_wr_drives: assert property (!write_strobe_n_o |-> !io_oe_n_o)
      else $error("write strobe with bus released");
   chk_rd_released: assert property (s_rd_fall |-> io_oe_n_o)
      else $error("host drives bus while reading");
   chk_strobe_excl: assert property (!(!write_strobe_n_o && !read_strobe_n_o))
      else $error("both strobes low");
   chk_idle_pins: assert property (s_idle |-> chip_sel_n_o && !write_protect_n_o)
      else $error("idle with chip selected or protect off");
   chk_done_pulse: assert property (done_o |=> !done_o)
      else $error("done longer than one cycle");
   chk_rd_pulse: assert property (rd_valid_o |=> !rd_valid_o)
      else $error("read valid longer than one cycle");
endmodule // nfh_host_asserts

// ===== verification/tb_nfh_host.sv
// Self-checking bench for the flash host controller
`timescale 1ns/10ps
module tb_nfh_host;
   logic             clk_i = 1'b0;
   logic             rst_n_i = 1'b0;
   logic             cmd_valid_i = 1'b0;
   nfh_pkg::nfh_op_e cmd_op_i = nfh_pkg::NFH_OP_STATUS;
   logic [11:0]      col_i = 12'h000;
   logic [5:0]       page_i = 6'h00;
   logic [9:0]       block_i = 10'h000;
   logic [11:0]      len_i = 12'h000;
   logic             wr_valid_i = 1'b0;
   logic [7:0]       wr_data_i = 8'h00;
   logic             slow = 1'b0;
   logic             cmd_ready_o, wr_ready_o, rd_valid_o, done_o, error_o, bad_block_o;
   logic             chip_sel_n_o, cle_o, ale_o, write_strobe_n_o, read_strobe_n_o;
   logic             write_protect_n_o, io_oe_n_o, ready_busy_n_i;
   logic [7:0]       rd_data_o, io_o, io_i, flash_io;
   logic [8:0]       exp_q [$];
   logic [7:0]       shadow [int];
   int               err_count = 0;
   int               tests_run = 0;
   int               done_cnt = 0;
   localparam logic [7:0] STAT_OK = 8'hE0;
   localparam logic [7:0] ECC_SEC = 8'h10;
   always #5 clk_i = ~clk_i;
   assign io_i = io_oe_n_o ? flash_io : io_o;
   // Time-outs cut short so a stalled flash is seen within a few microseconds
   nfh_host #(.FETCH_TO(200), .PROG_TO(200), .ERASE_TO(300), .RST_TO(200)) nfh_host_i (.*);
   nfh_flash_model #(.STAT_OK(STAT_OK), .ECC_SEC(ECC_SEC)) nfh_flash_model_i (
      .chip_sel_n_i(chip_sel_n_o), .cle_i(cle_o), .ale_i(ale_o),
      .write_strobe_n_i(write_strobe_n_o), .read_strobe_n_i(read_strobe_n_o),
      .write_protect_n_i(write_protect_n_o), .io_i(io_o), .slow_i(slow),
      .io_o(flash_io), .ready_busy_n_o(ready_busy_n_i));
   task automatic chk(input logic [8:0] seen, input logic [8:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic wrap_up;
      $display("comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   always @(posedge clk_i) begin
      if (rst_n_i && rd_valid_o === 1'b1)
         chk({1'b0, rd_data_o}, exp_q.size() ? exp_q.pop_front() : 9'h1EE, "byte");
      if (rst_n_i && done_o === 1'b1) begin
         done_cnt++;
         chk({7'h40, bad_block_o, error_o}, exp_q.size() ? exp_q.pop_front() : 9'h0EE, "done");
      end
   end
   task automatic run(input nfh_pkg::nfh_op_e op, input logic [9:0] blk, input logic [5:0] pg,
                      input logic [11:0] col, input logic [11:0] len, input logic [1:0] flg);
      int k;
      int n;
      int i;
      int start;
      int base;
      logic [7:0] wd [$];
      base = int'({blk, pg, 12'h000});
      n = (op == nfh_pkg::NFH_OP_ECCSTAT) ? 4 : 1;
      if (op == nfh_pkg::NFH_OP_READ || op == nfh_pkg::NFH_OP_PROGRAM)
         n = (int'(len) > 2112 - int'(col)) ? 2112 - int'(col) : int'(len);
      for (k = 0; k < n; k++) begin
         wd.push_back(8'($urandom));
         if (op == nfh_pkg::NFH_OP_PROGRAM && flg == 2'b00) shadow[base + col + k] = wd[k];
         if (op == nfh_pkg::NFH_OP_READ)
            exp_q.push_back({1'b0, shadow.exists(base + col + k) ? shadow[base + col + k] : 8'hFF});
         else if (op == nfh_pkg::NFH_OP_STATUS)
            exp_q.push_back({1'b0, STAT_OK});
         else if (op == nfh_pkg::NFH_OP_ECCSTAT)
            exp_q.push_back({1'b0, ECC_SEC + 8'(k)});
      end
      if (op == nfh_pkg::NFH_OP_ERASE)
         for (k = 0; k < 262144; k++) shadow.delete(int'({blk, 18'h0}) + k);
      exp_q.push_back({7'h40, flg});
      {cmd_op_i, block_i, page_i, col_i, len_i} = {op, blk, pg, col, len};
      cmd_valid_i = 1'b1;
      start = done_cnt;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (cmd_ready_o !== 1'b1 && k < 5000);
      #1 cmd_valid_i = 1'b0;
      i = 0;
      wr_valid_i = (op == nfh_pkg::NFH_OP_PROGRAM);
      wr_data_i = wd[0];
      for (k = k; k < 30000 && done_cnt == start; k++) begin
         @(posedge clk_i);
         if (wr_valid_i && wr_ready_o === 1'b1) begin
            i++;
            #1 wr_valid_i = (i < n);
            wr_data_i = wd[i % n];
         end
      end
      // Step off the edge so the next command never races the sampling edge
      #1 wr_valid_i = 1'b0;
      $display("test %s finished", op.name());
      if (k >= 30000) begin
         chk(9'h001, 9'h000, "wait ran out");
         wrap_up();
      end
   endtask
   initial begin
      int j;
      void'($urandom(6555));
      repeat (12) @(posedge clk_i);
      #1 rst_n_i = 1'b1;
      chk({6'h00, chip_sel_n_o, write_protect_n_o, io_oe_n_o}, 9'h005, "idle pins");
      run(nfh_pkg::NFH_OP_PROGRAM, 10'd5, 6'd3, 12'd0, 12'd8, 2'b00);
      run(nfh_pkg::NFH_OP_READ, 10'd5, 6'd3, 12'd0, 12'd12, 2'b00);
      run(nfh_pkg::NFH_OP_READ, 10'd5, 6'd3, 12'd2108, 12'd8, 2'b00);
      run(nfh_pkg::NFH_OP_STATUS, 10'd0, 6'd0, 12'd0, 12'd0, 2'b00);
      run(nfh_pkg::NFH_OP_ECCSTAT, 10'd0, 6'd0, 12'd0, 12'd0, 2'b00);
      for (j = 1; j < 5; j++)
         run(nfh_pkg::NFH_OP_PROGRAM, 10'd5, 6'd3, 12'(16 * j), 12'd4, {1'b0, j == 4});
      run(nfh_pkg::NFH_OP_READ, 10'd5, 6'd3, 12'd0, 12'd80, 2'b00);
      run(nfh_pkg::NFH_OP_ERASE, 10'd5, 6'd0, 12'd0, 12'd0, 2'b00);
      run(nfh_pkg::NFH_OP_READ, 10'd5, 6'd3, 12'd0, 12'd4, 2'b00);
      run(nfh_pkg::NFH_OP_PROGRAM, 10'd5, 6'd3, 12'd0, 12'd4, 2'b00);
      run(nfh_pkg::NFH_OP_READ, 10'd1003, 6'd0, 12'd0, 12'd1, 2'b00);
      run(nfh_pkg::NFH_OP_READ, 10'd1004, 6'd0, 12'd0, 12'd1, 2'b10);
      slow = 1'b1;
      run(nfh_pkg::NFH_OP_ERASE, 10'd7, 6'd0, 12'd0, 12'd0, 2'b01);
      slow = 1'b0;
      run(nfh_pkg::NFH_OP_RESET, 10'd0, 6'd0, 12'd0, 12'd0, 2'b00);
      for (j = 0; j < 2; j++) begin
         block_i = 10'($urandom % 1004);
         page_i = 6'($urandom);
         col_i = 12'($urandom % 2100);
         run(nfh_pkg::NFH_OP_PROGRAM, block_i, page_i, col_i, 12'd6, 2'b00);
         run(nfh_pkg::NFH_OP_READ, block_i, page_i, col_i, 12'd6, 2'b00);
      end
      wrap_up();
   end
endmodule // tb_nfh_host
bind nfh_host nfh_host_asserts nfh_host_asserts_i (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
   .done_o(done_o), .rd_valid_o(rd_valid_o), .chip_sel_n_o(chip_sel_n_o), .cle_o(cle_o),
   .ale_o(ale_o), .write_strobe_n_o(write_strobe_n_o), .read_strobe_n_o(read_strobe_n_o),
   .write_protect_n_o(write_protect_n_o), .io_o(io_o), .io_oe_n_o(io_oe_n_o));
